/* logic/pulse_timer_pkg.sv */
// Purpose: Constants shared by the pulse width timer files.
// Assumes: Register bus with 32-bit data and byte addresses.
// Notes:   Field positions follow the control/status word layout.
package pulse_timer_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [3:0] CONTROL_STATUS_WORD_OFS = 4'h0;
  localparam logic [3:0] COUNT_WIDTH_WORD_OFS    = 4'h4;

  // ---------------------------------------------------------------------------
  // Control/status word fields
  // ---------------------------------------------------------------------------
  localparam int OVERFLOW_BIT     = 0;
  localparam int READY_BIT        = 1;
  localparam int SOFT_RESET_BIT   = 3;
  localparam int OVF_IRQ_EN_BIT   = 4;
  localparam int RDY_IRQ_EN_BIT   = 5;
  localparam int GLOBAL_IRQ_BIT   = 6;
  localparam int ENABLE_BIT       = 7;
  localparam int DIVIDE_LSB       = 8;
  localparam int EDGE_LSB         = 11;
  localparam int INPUT_SEL_LSB    = 13;
  localparam int CLOCK_SRC_BIT    = 15;
  localparam int UPPER_HALF_LSB   = 16;

  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_MAX  = 16'hffff;
  localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Edge modes
  // ---------------------------------------------------------------------------
  localparam logic [1:0] EDGE_FALL_PERIOD = 2'h0;
  localparam logic [1:0] EDGE_RISE_FIRST  = 2'h1;
  localparam logic [1:0] EDGE_FALL_FIRST  = 2'h2;
  localparam logic [1:0] EDGE_RISE_PERIOD = 2'h3;

  typedef enum logic [1:0] {
    WAIT_TRIGGER,
    MEASURING
  } meas_state_e;

endpackage : pulse_timer_pkg

/* logic/clock_divider.sv */
// Purpose: Prescaler producing one-cycle count ticks from a selected source.
// Assumes: Alternative clock already synchronous to ref_clk, below 1/4 rate.
// Notes:   Restart clears the divider output so the next tick is a full period.
`timescale 1ns/1ps
`default_nettype none
module clock_divider
  import pulse_timer_pkg::*;
#(
  parameter int DIV_W = 3
) (
  input  wire logic             ref_clk,     // Bus clock
  input  wire logic             nrst,        // Async reset, active low
  input  wire logic             alt_clk_in,  // Alternative clock level
  input  wire logic             src_sel,     // 0 bus clock, 1 alternative
  input  wire logic [DIV_W-1:0] divide_sel,  // Divide by 2**divide_sel
  input  wire logic             restart,     // Clear prescaler output
  output logic                  tick         // One-cycle count tick
);

  logic       alt_q_reg;
  logic [7:0] div_cnt_reg;
  logic       src_edge;
  logic [7:0] div_mask;

  assign div_mask = 8'((9'h1 << divide_sel) - 9'h1);
  assign src_edge = src_sel ? (alt_clk_in & ~alt_q_reg) : 1'b1;  // see R3 R24
  assign tick     = src_edge & ((div_cnt_reg & div_mask) == div_mask) & ~restart;  // see R2

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      alt_q_reg <= 1'b0;
    end else begin
      alt_q_reg <= alt_clk_in;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt_reg <= 8'h00;
    end else if (restart) begin
      div_cnt_reg <= 8'h00;  // see R5
    end else if (src_edge) begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end

endmodule : clock_divider
`default_nettype wire

/* logic/pulse_timer.sv */
// Purpose: Pulse width timer with edge-chosen captures and read buffers.
// Assumes: Pulse inputs may be asynchronous; register port is synchronous.
// Notes:   Read data is valid the cycle after the read strobe only.
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// How it works
// R1: A 16-bit up-counter advances once per divided prescaler tick.
// R2: Prescaler divides the source by 1 to 128 per three-bit field.
// R3: Prescaler source is the bus clock or alternative clock input.
// R4: Counter runs once enabled; first trigger edge clears it without capture.
// R5: Later measured edges capture the count, then zero counter and prescaler.
// R6: Counter wrap from all ones to zero sets the overflow flag.
// R7: One of four pulse inputs is chosen by the input-select field.
// R8: Selected input is synchronised to the clock; very short pulses may vanish.
// R9: Mode 00: falling trigger; later falls capture positive width (period).
// R10: Mode 11: rising trigger; later rises capture negative width (period).
// R11: Mode 01: rising trigger; falls capture positive, rises negative.
// R12: Mode 10: falling trigger; rises capture negative, falls positive.
// R13: Ready sets per mode: single update, or pairs (positive-then-negative in 01, negative-then-positive in 10).
// R14: On ready set, widths copy into read buffers that software reads.
// R15: Ready clears by read then write 0; buffers hold until cleared.
// R16: A capture during the ready clear keeps ready set and refreshes buffers.
// R17: Buffering restarts on reset, soft reset, or enable cycled off and on.
// R18: Counter and prescaler restart within one cycle after a capture.
// R19: Soft reset bit reads 0; writing 1 resets counter, edges, capture logic.
// R20: Soft reset zeroes widths and both flags, keeps configuration.
// R21: Enable 0 acts as soft reset held until enable is set again.
// R22: Interrupt is global enable and either enabled flag; measurement continues.
// R23: Overflow clears by writing 0; write 1 ignored; new overflow wins.
// R24: Clock select 0 picks the bus clock, 1 the alternative clock.
// R25: Input-select 00 to 11 route pulse inputs 0 to 3.
// R26: Two-stage synchroniser and sample comparison detect both edges.
module pulse_timer
  import pulse_timer_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int NUM_INPUTS = 4
) (
  input  wire logic                  ref_clk,                 // Bus clock
  input  wire logic                  nrst,                    // Async reset, active low
  input  wire logic [NUM_INPUTS-1:0] pulse_input,             // Pulse sources
  input  wire logic                  alternative_clock_input, // Alternative count clock
  input  wire logic [3:0]            reg_addr,                // Byte address
  input  wire logic [31:0]           reg_wdata,               // Write data
  input  wire logic                  reg_write,               // Write strobe
  input  wire logic                  reg_read,                // Read strobe
  output logic      [31:0]           reg_rdata,               // Read data, next cycle
  output logic                       irq                      // Interrupt request
);

  // ---------------------------------------------------------------------------
  // Configuration
  // ---------------------------------------------------------------------------
  logic       clock_source_sel_reg;
  logic [1:0] input_select_reg;
  logic [1:0] edge_mode_reg;
  logic [2:0] divide_sel_reg;
  logic       module_enable_reg;
  logic       global_irq_enable_reg;
  logic       ready_irq_enable_reg;
  logic       overflow_irq_enable_reg;

  logic       wr_ctrl;
  logic       rd_ctrl;
  logic       soft_reset;
  logic       block_clear;

  assign wr_ctrl    = reg_write && (reg_addr == CONTROL_STATUS_WORD_OFS);
  assign rd_ctrl    = reg_read && (reg_addr == CONTROL_STATUS_WORD_OFS);
  assign soft_reset = wr_ctrl && reg_wdata[SOFT_RESET_BIT];  // see R19
  // Disabled state holds everything in soft reset until re-enabled
  assign block_clear = soft_reset || !module_enable_reg ||
                       (wr_ctrl && !reg_wdata[ENABLE_BIT]);  // see R21 R17

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      clock_source_sel_reg    <= 1'b0;
      input_select_reg        <= 2'h0;
      edge_mode_reg           <= 2'h0;
      divide_sel_reg          <= 3'h0;
      module_enable_reg       <= 1'b0;
      global_irq_enable_reg   <= 1'b0;
      ready_irq_enable_reg    <= 1'b0;
      overflow_irq_enable_reg <= 1'b0;
    end else if (wr_ctrl) begin
      clock_source_sel_reg    <= reg_wdata[CLOCK_SRC_BIT];  // see R20
      input_select_reg        <= reg_wdata[INPUT_SEL_LSB +: 2];
      edge_mode_reg           <= reg_wdata[EDGE_LSB +: 2];
      divide_sel_reg          <= reg_wdata[DIVIDE_LSB +: 3];
      module_enable_reg       <= reg_wdata[ENABLE_BIT];
      global_irq_enable_reg   <= reg_wdata[GLOBAL_IRQ_BIT];
      ready_irq_enable_reg    <= reg_wdata[RDY_IRQ_EN_BIT];
      overflow_irq_enable_reg <= reg_wdata[OVF_IRQ_EN_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // Input select, synchroniser and edge detect
  // ---------------------------------------------------------------------------
  logic sync1_reg;
  logic sync2_reg;
  logic sample_reg;
  logic rise;
  logic fall;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pulse_input[input_select_reg];  // see R7 R25 R8
      sync2_reg <= sync1_reg;  // see R26
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sample_reg <= 1'b0;
    end else begin
      sample_reg <= sync2_reg;
    end
  end

  assign rise = !block_clear && sync2_reg && !sample_reg;  // see R26
  assign fall = !block_clear && !sync2_reg && sample_reg;

  // ---------------------------------------------------------------------------
  // Trigger and capture decisions
  // ---------------------------------------------------------------------------
  meas_state_e state_reg;
  meas_state_e state_next;
  logic        trigger_edge;
  logic        cap_pos;
  logic        cap_neg;

  always_comb begin
    trigger_edge = 1'b0;
    cap_pos      = 1'b0;
    cap_neg      = 1'b0;
    state_next   = state_reg;
    case (state_reg)
      WAIT_TRIGGER: begin
        case (edge_mode_reg)
          EDGE_RISE_FIRST, EDGE_RISE_PERIOD: trigger_edge = rise;  // see R10 R11
          default:                           trigger_edge = fall;  // see R9 R12
        endcase
        if (trigger_edge) begin
          state_next = MEASURING;  // see R4
        end
      end
      MEASURING: begin
        case (edge_mode_reg)
          EDGE_FALL_PERIOD: cap_pos = fall;  // see R9
          EDGE_RISE_PERIOD: cap_neg = rise;  // see R10
          default: begin
            cap_pos = fall;  // see R11 R12
            cap_neg = rise;
          end
        endcase
      end
      default: state_next = WAIT_TRIGGER;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= WAIT_TRIGGER;
    end else if (block_clear) begin
      state_reg <= WAIT_TRIGGER;  // see R19
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Prescaler and counter
  // ---------------------------------------------------------------------------
  logic             tick;
  logic             restart;
  logic [CNT_W-1:0] running_count_reg;
  logic             wrap;

  // Restart on the capture cycle itself: the capture takes the old count
  assign restart = block_clear || trigger_edge || cap_pos || cap_neg;  // see R18 R5

  clock_divider #(
    .DIV_W (3)
  ) u_clock_divider (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .alt_clk_in (alternative_clock_input),
    .src_sel    (clock_source_sel_reg),
    .divide_sel (divide_sel_reg),
    .restart    (restart),
    .tick       (tick)
  );

  assign wrap = tick && (running_count_reg == CNT_W'(COUNT_MAX));  // see R6

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      running_count_reg <= CNT_W'(COUNT_ZERO);
    end else if (restart) begin
      running_count_reg <= CNT_W'(COUNT_ZERO);  // see R4 R5 R19
    end else if (tick) begin
      running_count_reg <= running_count_reg + CNT_W'(1);  // see R1
    end
  end

  // ---------------------------------------------------------------------------
  // Width registers, ready tracking and read buffers
  // ---------------------------------------------------------------------------
  logic [CNT_W-1:0] positive_width_reg;
  logic [CNT_W-1:0] negative_width_reg;
  logic [CNT_W-1:0] pos_buf_reg;
  logic [CNT_W-1:0] neg_buf_reg;
  logic             pos_seen_reg;
  logic             neg_seen_reg;
  logic             ready_set;
  logic             data_ready_flag_reg;
  logic             overflow_flag_reg;
  logic             ready_read_reg;
  logic [CNT_W-1:0] pos_new;
  logic [CNT_W-1:0] neg_new;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      positive_width_reg <= CNT_W'(COUNT_ZERO);
      negative_width_reg <= CNT_W'(COUNT_ZERO);
    end else if (block_clear) begin
      positive_width_reg <= CNT_W'(COUNT_ZERO);  // see R20
      negative_width_reg <= CNT_W'(COUNT_ZERO);
    end else begin
      if (cap_pos) begin
        positive_width_reg <= running_count_reg;  // see R5 R15
      end
      if (cap_neg) begin
        negative_width_reg <= running_count_reg;
      end
    end
  end

  // Pair tracking: mode 01 needs positive then negative, mode 10 the reverse
  always_comb begin
    ready_set = 1'b0;
    case (edge_mode_reg)
      EDGE_FALL_PERIOD: ready_set = cap_pos;  // see R13
      EDGE_RISE_PERIOD: ready_set = cap_neg;
      EDGE_RISE_FIRST:  ready_set = cap_neg && pos_seen_reg;
      EDGE_FALL_FIRST:  ready_set = cap_pos && neg_seen_reg;
      default:          ready_set = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pos_seen_reg <= 1'b0;
      neg_seen_reg <= 1'b0;
    end else if (block_clear || ready_set) begin
      pos_seen_reg <= 1'b0;  // see R17
      neg_seen_reg <= 1'b0;
    end else begin
      if (cap_pos) begin
        pos_seen_reg <= 1'b1;
      end
      if (cap_neg) begin
        neg_seen_reg <= 1'b1;
      end
    end
  end

  assign pos_new = cap_pos ? running_count_reg : positive_width_reg;
  assign neg_new = cap_neg ? running_count_reg : negative_width_reg;

  // Remembers that software has read the flag while set, arming the clear
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ready_read_reg <= 1'b0;
    end else if (block_clear || !data_ready_flag_reg) begin
      ready_read_reg <= 1'b0;
    end else if (rd_ctrl) begin
      ready_read_reg <= 1'b1;  // see R15
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      data_ready_flag_reg <= 1'b0;
    end else if (block_clear) begin
      data_ready_flag_reg <= 1'b0;  // see R20
    end else if (ready_set || (cap_pos || cap_neg) && data_ready_flag_reg) begin
      data_ready_flag_reg <= 1'b1;  // see R16
    end else if (wr_ctrl && !reg_wdata[READY_BIT] && ready_read_reg) begin
      data_ready_flag_reg <= 1'b0;  // see R15
    end
  end

  // Buffers load on first ready set, or on a capture racing the clear
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pos_buf_reg <= CNT_W'(COUNT_ZERO);
      neg_buf_reg <= CNT_W'(COUNT_ZERO);
    end else if (block_clear) begin
      pos_buf_reg <= CNT_W'(COUNT_ZERO);  // see R19
      neg_buf_reg <= CNT_W'(COUNT_ZERO);
    end else if ((ready_set && !data_ready_flag_reg) ||
                 ((cap_pos || cap_neg) && wr_ctrl && !reg_wdata[READY_BIT] &&
                  ready_read_reg)) begin
      pos_buf_reg <= pos_new;  // see R14 R16
      neg_buf_reg <= neg_new;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      overflow_flag_reg <= 1'b0;
    end else if (block_clear) begin
      overflow_flag_reg <= 1'b0;  // see R20
    end else if (wrap) begin
      overflow_flag_reg <= 1'b1;  // see R6 R23
    end else if (wr_ctrl && !reg_wdata[OVERFLOW_BIT]) begin
      overflow_flag_reg <= 1'b0;  // see R23
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt and read port
  // ---------------------------------------------------------------------------
  assign irq = global_irq_enable_reg &&
               ((overflow_flag_reg && overflow_irq_enable_reg) ||
                (data_ready_flag_reg && ready_irq_enable_reg));  // see R22

  logic [31:0] rdata_next;

  always_comb begin
    rdata_next = WORD_ZERO;
    case (reg_addr)
      CONTROL_STATUS_WORD_OFS: begin
        rdata_next[UPPER_HALF_LSB +: 16] = 16'(pos_buf_reg);  // see R14
        rdata_next[CLOCK_SRC_BIT]        = clock_source_sel_reg;
        rdata_next[INPUT_SEL_LSB +: 2]   = input_select_reg;
        rdata_next[EDGE_LSB +: 2]        = edge_mode_reg;
        rdata_next[DIVIDE_LSB +: 3]      = divide_sel_reg;
        rdata_next[ENABLE_BIT]           = module_enable_reg;
        rdata_next[GLOBAL_IRQ_BIT]       = global_irq_enable_reg;
        rdata_next[RDY_IRQ_EN_BIT]       = ready_irq_enable_reg;
        rdata_next[OVF_IRQ_EN_BIT]       = overflow_irq_enable_reg;
        rdata_next[READY_BIT]            = data_ready_flag_reg;
        rdata_next[OVERFLOW_BIT]         = overflow_flag_reg;
      end
      COUNT_WIDTH_WORD_OFS: begin
        rdata_next[UPPER_HALF_LSB +: 16] = 16'(running_count_reg);
        rdata_next[15:0]                 = 16'(neg_buf_reg);
      end
      default: rdata_next = WORD_ZERO;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= WORD_ZERO;
    end else begin
      reg_rdata <= reg_read ? rdata_next : WORD_ZERO;
    end
  end

endmodule : pulse_timer
`default_nettype wire

/* tb/pulse_timer_monitor.sv */
// Purpose: Port assertions for the pulse width timer.
// Assumes: One clock, async active-low reset.
// Notes:   Bound to every pulse_timer instance after the module.
`timescale 1ns/1ps
`default_nettype none
module pulse_timer_monitor
  import pulse_timer_pkg::*;
#(
  parameter int CNT_W      = 16,
  parameter int NUM_INPUTS = 4
) (
  input wire logic                  ref_clk, // Clock
  input wire logic                  nrst, // Reset
  input wire logic [NUM_INPUTS-1:0] pulse_input, // Pulses
  input wire logic                  alternative_clock_input, // Alt clock
  input wire logic [3:0]            reg_addr, // Address
  input wire logic [31:0]           reg_wdata, // Write data
  input wire logic                  reg_write, // Write strobe
  input wire logic                  reg_read, // Read strobe
  input wire logic [31:0]           reg_rdata, // Read data
  input wire logic                  irq // Interrupt
);
  logic        rd_reg;
  logic        rd0_reg;
  logic        held_ok_reg;
  logic [15:0] held_reg;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_reg  <= 1'b0;
      rd0_reg <= 1'b0;
    end else begin
      rd_reg  <= reg_read;
      rd0_reg <= reg_read && reg_addr == CONTROL_STATUS_WORD_OFS;
    end
  end

  // Any write may legally refresh the buffers, so it ends the hold chain
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      held_ok_reg <= 1'b0;
      held_reg    <= COUNT_ZERO;
    end else if (reg_write) begin
      held_ok_reg <= 1'b0;
    end else if (rd0_reg && reg_rdata[READY_BIT]) begin
      held_ok_reg <= 1'b1;
      held_reg    <= reg_rdata[31:16];
    end
  end

  // ------------
  // Assertions
  // ------------
  sequence ctl_read_s; reg_read && reg_addr == CONTROL_STATUS_WORD_OFS; endsequence
  sequence cnt_read_s; reg_read && reg_addr == COUNT_WIDTH_WORD_OFS; endsequence
  sequence off_write_s;
    reg_write && reg_addr == CONTROL_STATUS_WORD_OFS && !reg_wdata[ENABLE_BIT];
  endsequence
  sequence sreset_write_s;
    reg_write && reg_addr == CONTROL_STATUS_WORD_OFS && reg_wdata[SOFT_RESET_BIT];
  endsequence

  rdata_idle_a:
    assert property (!rd_reg |-> reg_rdata == WORD_ZERO)
    else $error("read data not zero outside its cycle");
  fixed_zero_bits_a:
    assert property (rd0_reg |-> reg_rdata[3:2] == 2'b00)
    else $error("soft reset or reserved bit read as one");
  irq_relation_a:
    assert property (rd0_reg |-> $past(irq) == (reg_rdata[GLOBAL_IRQ_BIT] &&
      ((reg_rdata[OVERFLOW_BIT] && reg_rdata[OVF_IRQ_EN_BIT]) ||
       (reg_rdata[READY_BIT] && reg_rdata[RDY_IRQ_EN_BIT]))))
    else $error("interrupt does not match flags and enables");
  irq_global_off_a:
    assert property (reg_write && reg_addr == CONTROL_STATUS_WORD_OFS &&
      !reg_wdata[GLOBAL_IRQ_BIT] |=> !irq)
    else $error("interrupt with global enable off");
  disabled_word_a:
    assert property (rd0_reg && !reg_rdata[ENABLE_BIT] |->
      reg_rdata[31:16] == COUNT_ZERO && reg_rdata[1:0] == 2'b00)
    else $error("disabled timer shows width or flag");
  disable_clear_a:
    assert property (off_write_s ##1 cnt_read_s |=> reg_rdata == WORD_ZERO)
    else $error("counter or negative width survive disable");
  soft_reset_a:
    assert property (sreset_write_s ##1 ctl_read_s |=> reg_rdata[31:16] == COUNT_ZERO &&
      reg_rdata[1:0] == 2'b00 && reg_rdata[15:4] == $past(reg_wdata[15:4], 2))
    else $error("soft reset result wrong");
  buffer_hold_a:
    assert property (rd0_reg && reg_rdata[READY_BIT] && held_ok_reg |->
      reg_rdata[31:16] == held_reg)
    else $error("read buffer changed while ready set");
endmodule : pulse_timer_monitor

bind pulse_timer pulse_timer_monitor #(.CNT_W(CNT_W), .NUM_INPUTS(NUM_INPUTS)) u_monitor (
  .ref_clk(ref_clk), .nrst(nrst), .pulse_input(pulse_input),
  .alternative_clock_input(alternative_clock_input), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .irq(irq));
`default_nettype wire

/* tb/pulse_source.sv */
// Purpose: Pulse source standing in for the measured signals.
// Assumes: Runs on the bus clock.
// Notes:   Idle lines sit low; unselected lines toggle while running.
`timescale 1ns/1ps
`default_nettype none
module pulse_source (
  input  wire logic       ref_clk, // Bus clock
  input  wire logic       run, // Start waveform
  input  wire logic [1:0] sel, // Line carrying the waveform
  input  wire logic [7:0] high_cyc, // High time in clocks
  input  wire logic [7:0] low_cyc, // Low time in clocks
  output logic      [3:0] pulse_out, // Pulse lines
  output logic            alt_clk // One eighth of the bus clock
);
  logic [7:0] cnt_reg = 8'h00;
  logic       level_reg = 1'b0;
  logic       noise_reg = 1'b0;
  logic [2:0] alt_reg = 3'h0;

  // Stretches last whole clocks, never below one sample
  always @(posedge ref_clk) begin
    noise_reg <= ~noise_reg;
    alt_reg   <= alt_reg + 3'h1;
    if (!run) begin
      cnt_reg   <= 8'h00;
      level_reg <= 1'b0;
    end else if (cnt_reg == (level_reg ? high_cyc : low_cyc) - 8'h01) begin
      cnt_reg   <= 8'h00;
      level_reg <= ~level_reg;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  // Noise on other lines exposes a wrong input choice
  always_comb begin
    pulse_out      = run ? {4{noise_reg}} : 4'h0;
    pulse_out[sel] = level_reg;
  end
  assign alt_clk = alt_reg[2];
endmodule : pulse_source
`default_nettype wire

/* tb/tb_pulse_timer.sv */
// Purpose: Self-checking bench for the pulse width timer.
// Assumes: Bus master drives just after the rising edge.
// Notes:   The overflow run takes about 66k clocks.
`timescale 1ns/1ps
`default_nettype none
module tb_pulse_timer
  import pulse_timer_pkg::*;
;
  localparam logic [7:0]  HIGH_CYC    = 8'h18;
  localparam logic [7:0]  LOW_CYC     = 8'h28;
  // Widths for edge modes 0 to 2 at divide 1, 2 and 4
  localparam logic [15:0] POS_EXP [4] = '{16'h003f, 16'h000b, 16'h0005, 16'h0000};
  localparam logic [15:0] NEG_EXP [4] = '{16'h0000, 16'h0013, 16'h0009, 16'h0007};
  logic        ref_clk, nrst, alt_clk, reg_write, reg_read, irq, run;
  logic [3:0]  pulse_input, reg_addr;
  logic [1:0]  sel;
  logic [31:0] reg_wdata, reg_rdata, d0, d4, c;
  int          err_total, checks_done;

  pulse_source u_source (.ref_clk(ref_clk), .run(run), .sel(sel), .high_cyc(HIGH_CYC),
    .low_cyc(LOW_CYC), .pulse_out(pulse_input), .alt_clk(alt_clk));
  pulse_timer u_dut (.ref_clk(ref_clk), .nrst(nrst), .pulse_input(pulse_input),
    .alternative_clock_input(alt_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ------------
  // Bus and check tasks
  // ------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
    @(posedge ref_clk);
  endtask : rd

  // Bounded poll; running out counts as a mismatch
  task automatic wait_bit(input int idx, input int limit);
    logic [31:0] d;
    int          n;
    d = WORD_ZERO;
    for (n = 0; n < limit && d[idx] !== 1'b1; n++) rd(CONTROL_STATUS_WORD_OFS, d);
    check("flag wait", {31'h0, d[idx]}, 32'h1);
  endtask : wait_bit

  // Flag bits written as one so a config write leaves them alone
  function automatic logic [31:0] cfg(input logic [1:0] edge_mode, input logic [1:0] in_sel,
                                      input logic [2:0] div, input logic src,
                                      input logic [1:0] irq_en);
    return {16'h0000, src, in_sel, edge_mode, div, 2'b11, irq_en, 4'h3};
  endfunction : cfg

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  // ------------
  // Main sequence
  // ------------
  initial begin
    {nrst, reg_write, reg_read, run, sel, reg_addr} = '0;
    reg_wdata   = WORD_ZERO;
    err_total   = 0;
    checks_done = 0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    rd(CONTROL_STATUS_WORD_OFS, d0);
    check("control reset", d0, WORD_ZERO);
    wr(COUNT_WIDTH_WORD_OFS, 32'hffff_ffff);
    rd(4'h8, d0);
    check("unmapped read", d0, WORD_ZERO);
    rd(COUNT_WIDTH_WORD_OFS, d4);
    check("count reset", d4, WORD_ZERO);
    for (int m = 0; m < 4; m++) begin
      c = cfg(m[1:0], m[1:0], (m == 3) ? 3'h0 : m[2:0], m == 3, 2'h2);
      sel <= m[1:0];
      wr(CONTROL_STATUS_WORD_OFS, c);
      run <= 1'b1;
      wait_bit(READY_BIT, 100);
      @(negedge ref_clk);
      check("ready irq", {31'h0, irq}, 32'h1);
      @(posedge ref_clk);
      rd(COUNT_WIDTH_WORD_OFS, d4);
      repeat (70) @(posedge ref_clk);
      rd(CONTROL_STATUS_WORD_OFS, d0);
      check("pos width", {16'h0, d0[31:16]}, {16'h0, POS_EXP[m]});
      // Alt clock phase is free, so one tick may differ
      if (m == 3) check("alt width", {31'h0, d4[15:0] inside {16'h7, 16'h8}}, 32'h1);
      else check("neg width", {16'h0, d4[15:0]}, {16'h0, NEG_EXP[m]});
      wr(CONTROL_STATUS_WORD_OFS, c & 32'hffff_fffd);
      rd(CONTROL_STATUS_WORD_OFS, d0);
      check("ready clear", {31'h0, d0[READY_BIT]}, 32'h0);
      wr(CONTROL_STATUS_WORD_OFS, c | 32'h0000_0008);
      rd(CONTROL_STATUS_WORD_OFS, d0);
      check("soft reset", d0, c & 32'h0000_fff0);
      run <= 1'b0;
      wr(CONTROL_STATUS_WORD_OFS, WORD_ZERO);
      rd(COUNT_WIDTH_WORD_OFS, d4);
      check("disabled", d4, WORD_ZERO);
    end
    c = cfg(2'h0, 2'h0, 3'h0, 1'b0, 2'h1);
    sel <= 2'h0;
    wr(CONTROL_STATUS_WORD_OFS, c);
    wait_bit(OVERFLOW_BIT, 34000);
    @(negedge ref_clk);
    check("overflow irq", {31'h0, irq}, 32'h1);
    @(posedge ref_clk);
    wr(CONTROL_STATUS_WORD_OFS, c);
    rd(CONTROL_STATUS_WORD_OFS, d0);
    check("overflow kept", {30'h0, d0[1:0]}, 32'h1);
    wr(CONTROL_STATUS_WORD_OFS, c & 32'hffff_fffe);
    rd(CONTROL_STATUS_WORD_OFS, d0);
    check("overflow clear", {30'h0, d0[1:0]}, 32'h0);
    stop_test();
  end
endmodule : tb_pulse_timer
`default_nettype wire
